// File: hdl/timer16_pkg.sv
// constants shared by the 16-bit timer and its prescaler
// assumes a 32-bit apb slave with one aligned word per register
package timer16_pkg;

    // register byte offsets
    localparam logic [11:0] CONTROL_OFFSET = 12'h000;
    localparam logic [11:0] COUNT_OFFSET = 12'h004;
    localparam logic [11:0] COMPARE_A_OFFSET = 12'h008;
    localparam logic [11:0] COMPARE_B_OFFSET = 12'h00C;
    localparam logic [11:0] CAPTURE_TOP_OFFSET = 12'h010;
    localparam logic [11:0] FLAGS_OFFSET = 12'h014;
    localparam logic [11:0] PIN_DIRECTION_OFFSET = 12'h018;

    // control register fields
    localparam int MODE_LSB = 0;
    localparam int ACTION_A_LSB = 4;
    localparam int ACTION_B_LSB = 6;
    localparam int CLOCK_SELECT_LSB = 8;

    // flag register bit positions
    localparam int OVERFLOW_BIT = 0;
    localparam int COMPARE_A_BIT = 1;
    localparam int COMPARE_B_BIT = 2;
    localparam int CAPTURE_BIT = 3;

    // reset values
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COMPARE_RESET = 16'h0000;
    localparam logic [15:0] CAPTURE_RESET = 16'h0000;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic [1:0] PIN_DIRECTION_RESET = 2'h0;

    // waveform mode select codes
    localparam logic [3:0] MODE_CTC_COMPARE = 4'h4;
    localparam logic [3:0] MODE_FAST_8BIT = 4'h5;
    localparam logic [3:0] MODE_FAST_9BIT = 4'h6;
    localparam logic [3:0] MODE_FAST_10BIT = 4'h7;
    localparam logic [3:0] MODE_CTC_CAPTURE = 4'hC;
    localparam logic [3:0] MODE_FAST_CAPTURE = 4'hE;
    localparam logic [3:0] MODE_FAST_COMPARE = 4'hF;

    // output action codes
    localparam logic [1:0] ACTION_NONE = 2'h0;
    localparam logic [1:0] ACTION_TOGGLE = 2'h1;
    localparam logic [1:0] ACTION_NON_INVERT = 2'h2;
    localparam logic [1:0] ACTION_INVERT = 2'h3;

    // counter limits and fixed tops
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam logic [15:0] COUNT_BOTTOM = 16'h0000;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;

    // prescaler: select codes and divide masks (divider minus one)
    localparam logic [2:0] CLOCK_STOPPED = 3'h0;
    localparam logic [2:0] CLOCK_DIV1 = 3'h1;
    localparam logic [2:0] CLOCK_DIV8 = 3'h2;
    localparam logic [2:0] CLOCK_DIV64 = 3'h3;
    localparam logic [2:0] CLOCK_DIV256 = 3'h4;
    localparam logic [2:0] CLOCK_DIV1024 = 3'h5;
    localparam logic [9:0] MASK_DIV1 = 10'h000;
    localparam logic [9:0] MASK_DIV8 = 10'h007;
    localparam logic [9:0] MASK_DIV64 = 10'h03F;
    localparam logic [9:0] MASK_DIV256 = 10'h0FF;
    localparam logic [9:0] MASK_DIV1024 = 10'h3FF;

endpackage : timer16_pkg

// File: hdl/prescale_if.sv
// carrier between the timer core and its prescaler
// assumes both ends run on the same apb clock
interface prescale_if;
    logic [2:0] clock_select;
    logic tick;

    modport timer (output clock_select, input tick);
    modport divider (input clock_select, output tick);
endinterface : prescale_if

// File: hdl/timer_prescaler.sv
// prescaler giving the timer clock enable from the i/o clock
// assumes clock_select comes from a register on the same clock
module timer_prescaler (
    input wire logic pclk,
    input wire logic presetn,
    prescale_if.divider pre
);

    logic [9:0] div_reg;
    logic [9:0] div_next;
    logic [9:0] mask;
    logic running;

    // divide mask for the chosen factor
    assign mask = (pre.clock_select == timer16_pkg::CLOCK_DIV8) ? timer16_pkg::MASK_DIV8 :
                  (pre.clock_select == timer16_pkg::CLOCK_DIV64) ? timer16_pkg::MASK_DIV64 :
                  (pre.clock_select == timer16_pkg::CLOCK_DIV256) ? timer16_pkg::MASK_DIV256 :
                  (pre.clock_select == timer16_pkg::CLOCK_DIV1024) ? timer16_pkg::MASK_DIV1024 :
                  timer16_pkg::MASK_DIV1;
    assign running = (pre.clock_select >= timer16_pkg::CLOCK_DIV1) &&
                     (pre.clock_select <= timer16_pkg::CLOCK_DIV1024);

    // one enable every divider cycles, none while stopped
    assign pre.tick = running && ((div_reg & mask) == mask);
    assign div_next = running ? 10'(div_reg + 10'h001) : 10'h000;

    // free divide counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_reg <= 10'h000;
        else
            div_reg <= div_next;
    end

endmodule : timer_prescaler

// File: hdl/timer16_pwm.sv
// 16-bit timer with clear-on-compare and fast pwm modes behind an apb slave
// assumes apb master on pclk; pins are outputs with enables, the pad resolves them
//
// What this block does
// - clear-on-compare clears count at compare a (mode 4) or capture top (mode 12).
// - clear-on-compare raises the flag of whichever register defines top.
// - clear-on-compare top is direct; a top below count runs to 0xFFFF, wraps.
// - action 1 in clear-on-compare toggles wave output a on every match.
// - wave state reaches the pin only while its direction bit is one.
// - clear-on-compare sets overflow as count rolls from maximum to zero.
// - toggle period is 2 times N times (1 plus compare a) clocks.
// - fast pwm modes 5,6,7,14,15 count up only, single slope.
// - fast pwm top is fixed, capture or compare a; clear the cycle after.
// - non-inverting sets on match, clears at top; inverting the opposite.
// - action two selects non-inverted pwm, three selects inverted pwm.
// - fast pwm sets overflow at top, with the top register's flag.
// - fast pwm sets a channel flag when count equals its compare value.
// - with a fixed top, compare writes store bits above resolution as zero.
// - capture top acts at once; a top below count wraps through 0xFFFF.
// - fast pwm compare a writes buffer; active loads at top with overflow.
// - a compare above top never matches; software keeps top above compares.
// - compare zero gives a one-cycle spike; compare at top a constant level.
// - action 1 toggles wave output a in fast pwm only in mode 15.
// - fast pwm period is N times (1 plus top) clocks.
// - normal and clear-on-compare modes write compare values directly.
// - action 0 leaves the wave output unchanged in every mode.
// - count maximum is 0xFFFF and restarts from zero after it.
module timer16_pwm (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic wave_a_pin_out,
    output logic wave_a_pin_oe,
    output logic wave_b_pin_out,
    output logic wave_b_pin_oe
);

    prescale_if pre ();

    logic [31:0] control_reg;
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic [15:0] capture_reg;
    logic [3:0] flags_reg;
    logic [3:0] flags_next;
    logic [1:0] pin_direction_reg;
    logic [31:0] prdata_reg;
    logic [31:0] read_mux;
    logic [15:0] cmp_buf_reg [2];
    logic [15:0] cmp_act_reg [2];
    logic [1:0] wave_reg;
    logic [1:0] action [2];
    logic [1:0] cmp_hit;
    logic [1:0] wr_cmp;

    logic access;
    logic setup;
    logic wr;
    logic hit_control;
    logic hit_count;
    logic hit_cmp_a;
    logic hit_cmp_b;
    logic hit_capture;
    logic hit_flags;
    logic hit_pin_dir;
    logic hit_any;

    logic [3:0] mode;
    logic ctc_mode;
    logic fast_mode;
    logic pwm_mode;
    logic [15:0] top_value;
    logic [15:0] res_mask;
    logic [15:0] wdata_masked;
    logic tick;
    logic at_top;
    logic top_pass;
    logic ovf_set;
    logic cap_set;
    logic [3:0] flag_set;
    logic [3:0] flag_clear;

    // timer clock enable from the prescaler
    timer_prescaler u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .pre(pre)
    );

    assign pre.clock_select = control_reg[timer16_pkg::CLOCK_SELECT_LSB +: 3];
    assign tick = pre.tick;

    // apb decode; zero wait states, unmapped addresses raise pslverr
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr = access && pwrite;
    assign hit_control = (paddr == timer16_pkg::CONTROL_OFFSET);
    assign hit_count = (paddr == timer16_pkg::COUNT_OFFSET);
    assign hit_cmp_a = (paddr == timer16_pkg::COMPARE_A_OFFSET);
    assign hit_cmp_b = (paddr == timer16_pkg::COMPARE_B_OFFSET);
    assign hit_capture = (paddr == timer16_pkg::CAPTURE_TOP_OFFSET);
    assign hit_flags = (paddr == timer16_pkg::FLAGS_OFFSET);
    assign hit_pin_dir = (paddr == timer16_pkg::PIN_DIRECTION_OFFSET);
    assign hit_any = hit_control || hit_count || hit_cmp_a || hit_cmp_b ||
                     hit_capture || hit_flags || hit_pin_dir;
    assign pready = 1'b1;
    assign pslverr = access && !hit_any;
    assign prdata = prdata_reg;
    assign wr_cmp[0] = wr && hit_cmp_a;
    assign wr_cmp[1] = wr && hit_cmp_b;

    // mode decode
    assign mode = control_reg[timer16_pkg::MODE_LSB +: 4];
    assign action[0] = control_reg[timer16_pkg::ACTION_A_LSB +: 2];
    assign action[1] = control_reg[timer16_pkg::ACTION_B_LSB +: 2];
    assign ctc_mode = (mode == timer16_pkg::MODE_CTC_COMPARE) ||
                      (mode == timer16_pkg::MODE_CTC_CAPTURE);
    assign fast_mode = (mode == timer16_pkg::MODE_FAST_8BIT) ||
                       (mode == timer16_pkg::MODE_FAST_9BIT) ||
                       (mode == timer16_pkg::MODE_FAST_10BIT) ||
                       (mode == timer16_pkg::MODE_FAST_CAPTURE) ||
                       (mode == timer16_pkg::MODE_FAST_COMPARE);
    // every code other than normal (0) and the two ctc codes is a pwm code
    assign pwm_mode = (mode != 4'h0) && !ctc_mode;

    // top selection; compare a top uses the active, not the buffered, value
    assign top_value = (mode == timer16_pkg::MODE_FAST_8BIT) ? timer16_pkg::TOP_8BIT :
                       (mode == timer16_pkg::MODE_FAST_9BIT) ? timer16_pkg::TOP_9BIT :
                       (mode == timer16_pkg::MODE_FAST_10BIT) ? timer16_pkg::TOP_10BIT :
                       ((mode == timer16_pkg::MODE_CTC_CAPTURE) ||
                        (mode == timer16_pkg::MODE_FAST_CAPTURE)) ? capture_reg :
                       ((mode == timer16_pkg::MODE_CTC_COMPARE) ||
                        (mode == timer16_pkg::MODE_FAST_COMPARE)) ? cmp_act_reg[0] :
                       timer16_pkg::COUNT_MAX;

    // resolution mask for compare writes under a fixed top
    assign res_mask = (mode == timer16_pkg::MODE_FAST_8BIT) ? timer16_pkg::TOP_8BIT :
                      (mode == timer16_pkg::MODE_FAST_9BIT) ? timer16_pkg::TOP_9BIT :
                      (mode == timer16_pkg::MODE_FAST_10BIT) ? timer16_pkg::TOP_10BIT :
                      timer16_pkg::COUNT_MAX;
    assign wdata_masked = pwdata[15:0] & res_mask;

    // top is an equality test, so a top written below count is missed until the wrap
    assign at_top = (ctc_mode || fast_mode) && (count_reg == top_value);
    assign top_pass = tick && fast_mode && at_top;

    // counter next value; a software write to count wins over the tick
    assign count_next = (wr && hit_count) ? pwdata[15:0] :
                        !tick ? count_reg :
                        at_top ? timer16_pkg::COUNT_BOTTOM :
                        16'(count_reg + 16'h0001);

    // counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count_reg <= timer16_pkg::COUNT_RESET;
        else
            count_reg <= count_next;
    end

    // flag sources; a compare above top is never reached and never matches
    assign ovf_set = tick && (fast_mode ? at_top : (count_reg == timer16_pkg::COUNT_MAX));
    assign cap_set = tick && (count_reg == capture_reg) &&
                     ((mode == timer16_pkg::MODE_CTC_CAPTURE) ||
                      (mode == timer16_pkg::MODE_FAST_CAPTURE));
    assign flag_set[timer16_pkg::OVERFLOW_BIT] = ovf_set;
    assign flag_set[timer16_pkg::COMPARE_A_BIT] = tick && cmp_hit[0];
    assign flag_set[timer16_pkg::COMPARE_B_BIT] = tick && cmp_hit[1];
    assign flag_set[timer16_pkg::CAPTURE_BIT] = cap_set;
    assign flag_clear = (wr && hit_flags) ? pwdata[3:0] : 4'h0;
    // write one to clear; a set in the same cycle wins
    assign flags_next = (flags_reg & ~flag_clear) | flag_set;

    // sticky flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags_reg <= timer16_pkg::FLAGS_RESET;
        else
            flags_reg <= flags_next;
    end

    // control, capture top and pin direction registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            control_reg <= timer16_pkg::CONTROL_RESET;
            capture_reg <= timer16_pkg::CAPTURE_RESET;
            pin_direction_reg <= timer16_pkg::PIN_DIRECTION_RESET;
        end
        else
        begin
            if (wr && hit_control)
                control_reg <= 32'(pwdata[10:0]); // upper control bits read as zero
            if (wr && hit_capture)
                capture_reg <= pwdata[15:0];
            if (wr && hit_pin_dir)
                pin_direction_reg <= pwdata[1:0];
        end
    end

    // read mux, latched in the setup phase so data comes from a flip-flop
    assign read_mux = hit_control ? control_reg :
                      hit_count ? {16'h0000, count_reg} :
                      hit_cmp_a ? {16'h0000, cmp_buf_reg[0]} :
                      hit_cmp_b ? {16'h0000, cmp_buf_reg[1]} :
                      hit_capture ? {16'h0000, capture_reg} :
                      hit_flags ? {28'h000_0000, flags_reg} :
                      hit_pin_dir ? 32'(pin_direction_reg) :
                      32'h0000_0000;

    // read data register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_reg <= 32'h0000_0000;
        else if (setup && !pwrite)
            prdata_reg <= read_mux;
    end

    // per channel compare buffer, active compare value and wave state
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_chan
        logic [15:0] act_next;
        logic wave_next;
        logic match;
        logic toggle_ok;

        assign cmp_hit[ch] = (count_reg == cmp_act_reg[ch]);
        assign match = tick && cmp_hit[ch];
        // fast pwm toggles only channel a and only with compare a as top
        assign toggle_ok = !fast_mode || ((ch == 0) && (mode == timer16_pkg::MODE_FAST_COMPARE));

        // direct write outside pwm, reload from buffer at top inside it
        assign act_next = (!pwm_mode && wr_cmp[ch]) ? wdata_masked :
                          (pwm_mode && top_pass) ? cmp_buf_reg[ch] :
                          cmp_act_reg[ch];

        // top action has priority, so compare equal to top gives a constant level
        assign wave_next =
            (action[ch] == timer16_pkg::ACTION_NONE) ? wave_reg[ch] :
            (action[ch] == timer16_pkg::ACTION_TOGGLE) ?
                ((match && toggle_ok) ? !wave_reg[ch] : wave_reg[ch]) :
            !fast_mode ?
                (match ? (action[ch] == timer16_pkg::ACTION_INVERT) : wave_reg[ch]) :
            top_pass ? (action[ch] == timer16_pkg::ACTION_INVERT) :
            match ? (action[ch] == timer16_pkg::ACTION_NON_INVERT) :
            wave_reg[ch];

        // buffer register holds the last write; active value drives the compare
        always_ff @(posedge pclk or negedge presetn)
        begin
            if (!presetn)
            begin
                cmp_buf_reg[ch] <= timer16_pkg::COMPARE_RESET;
                cmp_act_reg[ch] <= timer16_pkg::COMPARE_RESET;
                wave_reg[ch] <= 1'b0;
            end
            else
            begin
                if (wr_cmp[ch])
                    cmp_buf_reg[ch] <= wdata_masked;
                cmp_act_reg[ch] <= act_next;
                wave_reg[ch] <= wave_next;
            end
        end
    end

    // pin drive follows the direction bits
    assign wave_a_pin_out = wave_reg[0];
    assign wave_a_pin_oe = pin_direction_reg[0];
    assign wave_b_pin_out = wave_reg[1];
    assign wave_b_pin_oe = pin_direction_reg[1];

endmodule : timer16_pwm

// File: testbench/timer16_pwm_properties.sv
// port checker for the 16-bit timer apb slave and its wave pins
// assumes it is bound to timer16_pwm and sees only that module's ports
module timer16_pwm_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic wave_a_pin_out,
    input wire logic wave_a_pin_oe,
    input wire logic wave_b_pin_out,
    input wire logic wave_b_pin_oe
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // access decode and a shadow of the clock select field
    logic [2:0] cs_reg;
    logic stop_d_reg;
    wire acc = psel && penable;
    wire mapped = (paddr[1:0] == 2'h0) && (paddr <= timer16_pkg::PIN_DIRECTION_OFFSET);
    wire dir_sel = paddr == timer16_pkg::PIN_DIRECTION_OFFSET;
    wire ctl_wr = acc && pwrite && (paddr == timer16_pkg::CONTROL_OFFSET);
    wire stopped = (cs_reg == 3'h0) || (cs_reg > 3'h5);

    // shadow follows control writes; stop flag stays one cycle behind so a last tick can settle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cs_reg <= 3'h0;
            stop_d_reg <= 1'b1;
        end
        else
        begin
            cs_reg <= ctl_wr ? pwdata[10:8] : cs_reg;
            stop_d_reg <= stopped;
        end
    end

    property p_ready;
        pready;
    endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_err_idle;
        !acc |-> !pslverr;
    endproperty
    a_err_idle: assert property (p_err_idle) else $error("pslverr outside access");
    property p_err_map;
        acc |-> pslverr == !mapped;
    endproperty
    a_err_map: assert property (p_err_map) else $error("pslverr does not match decode");
    property p_rd_unmapped;
        acc && !pwrite && !mapped |-> prdata == 32'h0000_0000;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
    property p_oe_wr;
        acc && pwrite && dir_sel |=> {wave_b_pin_oe, wave_a_pin_oe} == $past(pwdata[1:0]);
    endproperty
    a_oe_wr: assert property (p_oe_wr) else $error("pin enables miss write");
    property p_oe_hold;
        !(acc && pwrite && dir_sel) |=> $stable({wave_b_pin_oe, wave_a_pin_oe});
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("pin enables moved");
    property p_dir_rd;
        acc && !pwrite && dir_sel |-> prdata == {30'h0, wave_b_pin_oe, wave_a_pin_oe};
    endproperty
    a_dir_rd: assert property (p_dir_rd) else $error("direction readback differs");
    property p_hold;
        stopped && stop_d_reg |=> $stable({wave_b_pin_out, wave_a_pin_out});
    endproperty
    a_hold: assert property (p_hold) else $error("wave moved while stopped");

    // main scenarios reached
    c_unmapped: cover property (acc && !mapped);
    c_dir_wr: cover property (acc && pwrite && dir_sel);
    c_wave_a: cover property ($changed(wave_a_pin_out));
endmodule : timer16_pwm_checker

bind timer16_pwm timer16_pwm_checker i_timer16_pwm_checker (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .wave_a_pin_out, .wave_a_pin_oe, .wave_b_pin_out,
    .wave_b_pin_oe);

// File: testbench/tb_timer16_pwm.sv
// self-checking bench for the 16-bit timer, driven over apb
// assumes the checker file is compiled too and binds itself
module tb_timer16_pwm;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic wave_a_pin_out;
    logic wave_a_pin_oe;
    logic wave_b_pin_out;
    logic wave_b_pin_oe;
    logic [31:0] q;
    logic err;
    int hi;
    int per;
    int mismatches = 0;
    int num_checks = 0;

    timer16_pwm i_timer16_pwm (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .wave_a_pin_out, .wave_a_pin_oe, .wave_b_pin_out, .wave_b_pin_oe);

    // 40 mhz clock
    initial
    begin
        forever #12.5 pclk = ~pclk;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task end_of_test;
        if (mismatches == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    // one apb transfer, held until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask : rd

    function logic [31:0] ctl(logic [3:0] m, logic [1:0] a, logic [1:0] b, logic [2:0] c);
        return {21'h0, c, b, a, m};
    endfunction : ctl

    function logic wv(bit b);
        return b ? wave_b_pin_out : wave_a_pin_out;
    endfunction : wv

    // high time and period of one wave, counted in settled clock cycles
    task meas(input bit b);
        while (wv(b) !== 1'b0) @(negedge pclk);
        while (wv(b) !== 1'b1) @(negedge pclk);
        hi = 0;
        while (wv(b) === 1'b1)
        begin
            @(negedge pclk);
            hi++;
        end
        per = hi;
        while (wv(b) === 1'b0)
        begin
            @(negedge pclk);
            per++;
        end
    endtask : meas

    // reset values, unmapped word, pin enable
    task t_regs;
        for (int i = 0; i < 8; i++)
        begin
            rd(12'(4 * i));
            chk(q, 32'h0000_0000);
            chk({31'h0, err}, 32'(i == 7));
        end
        wr(timer16_pkg::PIN_DIRECTION_OFFSET, 32'h0000_0001);
        @(negedge pclk);
        chk({30'h0, wave_b_pin_oe, wave_a_pin_oe}, 32'h0000_0001);
    endtask : t_regs

    // toggle in clear-on-compare with top 3 at prescale n
    task t_ctc(input logic [2:0] c, input int n);
        wr(timer16_pkg::CONTROL_OFFSET, ctl(timer16_pkg::MODE_CTC_COMPARE, 2'h1, 2'h0, 3'h0));
        wr(timer16_pkg::COMPARE_A_OFFSET, 32'h0000_0003);
        wr(timer16_pkg::CONTROL_OFFSET, ctl(timer16_pkg::MODE_CTC_COMPARE, 2'h1, 2'h0, c));
        meas(1'b0);
        chk(32'(hi), 32'(4 * n));
        chk(32'(per), 32'(8 * n));
    endtask : t_ctc

    // fast pwm with compare a as top 5, channel b compare 1
    task t_fast;
        wr(timer16_pkg::CONTROL_OFFSET, ctl(timer16_pkg::MODE_FAST_COMPARE, 2'h1, 2'h2, 3'h0));
        wr(timer16_pkg::COMPARE_A_OFFSET, 32'h0000_0005);
        wr(timer16_pkg::COMPARE_B_OFFSET, 32'h0000_0001);
        wr(timer16_pkg::CONTROL_OFFSET, ctl(timer16_pkg::MODE_FAST_COMPARE, 2'h1, 2'h2, 3'h1));
        meas(1'b1);
        meas(1'b1);
        chk(32'(hi), 32'h0000_0004);
        chk(32'(per), 32'h0000_0006);
        meas(1'b0);
        chk(32'(per), 32'h0000_000C);
        wr(timer16_pkg::CONTROL_OFFSET, ctl(timer16_pkg::MODE_FAST_COMPARE, 2'h1, 2'h3, 3'h1));
        meas(1'b1);
        chk(32'(hi), 32'h0000_0002);
        wr(timer16_pkg::CONTROL_OFFSET, ctl(timer16_pkg::MODE_FAST_COMPARE, 2'h1, 2'h3, 3'h0));
        rd(timer16_pkg::FLAGS_OFFSET);
        chk(q, 32'h0000_0007);
        wr(timer16_pkg::FLAGS_OFFSET, 32'h0000_000F);
        rd(timer16_pkg::FLAGS_OFFSET);
        chk(q, 32'h0000_0000);
    endtask : t_fast

    // fixed tops mask the compare write
    task t_mask;
        for (int i = 0; i < 3; i++)
        begin
            wr(timer16_pkg::CONTROL_OFFSET, ctl(4'(5 + i), 2'h0, 2'h0, 3'h0));
            wr(timer16_pkg::COMPARE_A_OFFSET, 32'h0000_FFFF);
            rd(timer16_pkg::COMPARE_A_OFFSET);
            chk(q, 32'((256 << i) - 1));
        end
    endtask : t_mask

    // capture top 4 with count already above it: run through the wrap
    task t_cap;
        logic w0;
        wr(timer16_pkg::CONTROL_OFFSET, ctl(timer16_pkg::MODE_CTC_CAPTURE, 2'h0, 2'h0, 3'h0));
        wr(timer16_pkg::CAPTURE_TOP_OFFSET, 32'h0000_0004);
        wr(timer16_pkg::COMPARE_A_OFFSET, 32'h0000_0002);
        wr(timer16_pkg::COMPARE_B_OFFSET, 32'h0000_00C8);
        wr(timer16_pkg::COUNT_OFFSET, 32'h0000_FFF0);
        wr(timer16_pkg::FLAGS_OFFSET, 32'h0000_000F);
        w0 = wave_a_pin_out;
        wr(timer16_pkg::CONTROL_OFFSET, ctl(timer16_pkg::MODE_CTC_CAPTURE, 2'h0, 2'h0, 3'h1));
        repeat (40) @(posedge pclk);
        wr(timer16_pkg::CONTROL_OFFSET, ctl(timer16_pkg::MODE_CTC_CAPTURE, 2'h0, 2'h0, 3'h0));
        rd(timer16_pkg::FLAGS_OFFSET);
        chk(q, 32'h0000_000B);
        chk({31'h0, wave_a_pin_out}, {31'h0, w0});
    endtask : t_cap

    // watchdog well past the expected run
    initial
    begin
        #(25 * 20000);
        mismatches++;
        $display("CHECK FAILED at %0t: timeout", $time);
        end_of_test();
    end

    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_ctc(3'h1, 1);
        t_ctc(3'h2, 8);
        t_fast();
        t_mask();
        t_cap();
        end_of_test();
    end
endmodule : tb_timer16_pwm
